//--- verilog/pmcb_pkg.sv
package pmcb_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] PLLB_CFG_OFS = 8'h2C;
    localparam logic [7:0] MCLK_CFG_OFS = 8'h30;
    localparam logic [7:0] PCK0_CFG_OFS = 8'h40;
    localparam logic [7:0] PCK1_CFG_OFS = 8'h44;
    localparam logic [7:0] IRQ_EN_OFS = 8'h60;
    localparam logic [7:0] IRQ_DIS_OFS = 8'h64;
    localparam logic [7:0] STATUS_OFS = 8'h68;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h6C;
    // second pll config field positions
    localparam int PDIV_LSB = 0;
    localparam int CNTB_LSB = 8;
    localparam int RANGE_LSB = 14;
    localparam int MULT_LSB = 16;
    localparam int USBD_LSB = 28;
    // master clock config fields
    localparam int SRC_LSB = 0;
    localparam int PSC_LSB = 2;
    localparam int MCK_DIV_LSB = 8;
    // status bit positions
    localparam int ST_MOSC = 0;
    localparam int ST_PLL1 = 1;
    localparam int ST_PLL2 = 2;
    localparam int ST_MRDY = 3;
    localparam int ST_OSCSEL = 7;
    localparam int ST_PCK0 = 8;
    localparam int ST_PCK1 = 9;
    // writable masks and reset values
    localparam logic [31:0] PLLB_MASK = 32'h37FF_FFFF;
    localparam logic [31:0] MCLK_MASK = 32'h0000_031F;
    localparam logic [31:0] PCK_MASK = 32'h0000_001F;
    localparam logic [31:0] IRQ_MASK = 32'h0000_030F;
    localparam logic [31:0] PLLB_RST = 32'h0000_3F00;
    localparam logic [31:0] MCLK_RST = 32'h0000_0000;
    localparam logic [31:0] PCK_RST = 32'h0000_0000;
    // source encoding and reserved divider codes
    localparam logic [1:0] SRC_SLOW = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_PLLA = 2'h2;
    localparam logic [1:0] SRC_PLLB = 2'h3;
    localparam logic [2:0] PSC_RSVD = 3'h7;
    localparam logic [1:0] DIV2_RSVD = 2'h3;
    // cycles of settling after a clock switch
    localparam int READY_DLY = 3;
endpackage

//--- verilog/pmcb_top.sv
// Functional notes
// - input divider: 0 gives no clock, 1 bypass, 2..255 divide by value.
// - after a pll config write count slow cycles then raise lock flag.
// - multiplier 0 stops the pll; otherwise output is input times mul+1.
// - usb divider: 00 pass, 01 halve, 10 quarter, 11 reserved.
// - master source: slow, main, first pll, second pll for 00..11.
// - processor prescaler divides by 1..64 for 000..110; 111 reserved.
// - master divider: processor clock by 1, 2, 4; 11 reserved.
// - each programmable clock has its own two-bit source selector.
// - each programmable clock has a three-bit prescaler 1..64.
// - writing one to enable register sets the matching enable.
// - writing one to disable register clears the matching enable.
// - enable, disable and status bits share positions 0-3, 8, 9.
// - oscillator stable bit follows main oscillator stability.
// - first pll lock bit follows that pll's lock.
// - second pll lock bit follows its lock state.
// - master clock ready bit reads one once the master clock is ready.
// - status bit 7 shows the slow oscillator in use.
// - each programmable clock ready bit shows that clock ready.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module pmcb_top
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic slow_tick_i,
    input wire logic main_osc_stable_i,
    input wire logic first_pll_locked_i,
    input wire logic slow_osc_select_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    output logic second_pll_on_o,
    output logic [7:0] second_pll_input_divider_o,
    output logic [10:0] second_pll_multiplier_o,
    output logic [1:0] second_pll_freq_range_o,
    output logic [2:0] usb_div_ratio_o,
    output logic [1:0] mclk_source_o,
    output logic [6:0] mclk_div_ratio_o,
    output logic [2:0] mclk_master_div_o,
    output logic [1:0] pck0_source_o,
    output logic [6:0] pck0_div_ratio_o,
    output logic [1:0] pck1_source_o,
    output logic [6:0] pck1_div_ratio_o
);
    import pmcb_pkg::*;

    typedef enum logic [1:0] {LK_IDLE, LK_COUNT, LK_DONE} pmcb_lock_type;

    logic [31:0] pllb_r;
    logic [31:0] mclk_r;
    logic [31:0] pck0_r;
    logic [31:0] pck1_r;
    logic [31:0] ien_r;
    logic [31:0] status;
    logic [5:0] lock_cnt_r;
    pmcb_lock_type lock_st_r;
    logic pll2_lock_r;
    logic [1:0] mrdy_cnt_r;
    logic mrdy_r;
    logic [1:0] p0_cnt_r;
    logic p0rdy_r;
    logic [1:0] p1_cnt_r;
    logic p1rdy_r;
    logic wr_pllb;
    logic wr_mclk;
    logic wr_pck0;
    logic wr_pck1;
    logic [31:0] wdata_last_r;

    // prescaler code to ratio, one-hot exponent; reserved code holds 0
    function automatic logic [6:0] prescale_ratio(input logic [2:0] code);
        logic [6:0] r;
        r = 7'h00;
        if (code != PSC_RSVD)
        begin
            r = 7'(7'h01 << code);
        end
        return r;
    endfunction

    // two-bit divider code to ratio 1, 2, 4; reserved code gives 0
    function automatic logic [2:0] div2_ratio(input logic [1:0] code);
        logic [2:0] r;
        r = 3'h0;
        if (code != DIV2_RSVD)
        begin
            r = 3'(3'h1 << code);
        end
        return r;
    endfunction

    assign wr_pllb = wr_i && addr_i == PLLB_CFG_OFS;
    assign wr_mclk = wr_i && addr_i == MCLK_CFG_OFS;
    assign wr_pck0 = wr_i && addr_i == PCK0_CFG_OFS;
    assign wr_pck1 = wr_i && addr_i == PCK1_CFG_OFS;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            pllb_r <= PLLB_RST;
            mclk_r <= MCLK_RST;
            pck0_r <= PCK_RST;
            pck1_r <= PCK_RST;
        end
        else
        begin
            if (wr_pllb)
            begin
                pllb_r <= wdata_i & PLLB_MASK;
            end
            if (wr_mclk)
            begin
                mclk_r <= wdata_i & MCLK_MASK;
            end
            if (wr_pck0)
            begin
                pck0_r <= wdata_i & PCK_MASK;
            end
            if (wr_pck1)
            begin
                pck1_r <= wdata_i & PCK_MASK;
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            ien_r <= 32'h0000_0000;
        end
        else if (wr_i && addr_i == IRQ_EN_OFS)
        begin
            ien_r <= ien_r | (wdata_i & IRQ_MASK);
        end
        else if (wr_i && addr_i == IRQ_DIS_OFS)
        begin
            ien_r <= ien_r & ~(wdata_i & IRQ_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // second pll lock counter on slow clock ticks
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            lock_st_r <= LK_IDLE;
            lock_cnt_r <= 6'h00;
            pll2_lock_r <= 1'b0;
        end
        else if (wr_pllb)
        begin
            pll2_lock_r <= 1'b0;
            lock_cnt_r <= wdata_i[CNTB_LSB +: 6];
            lock_st_r <= LK_COUNT;
        end
        else
        begin
            case (lock_st_r)
                LK_COUNT:
                begin
                    if (lock_cnt_r == 6'h00)
                    begin
                        pll2_lock_r <= 1'b1;
                        lock_st_r <= LK_DONE;
                    end
                    else if (slow_tick_i)
                    begin
                        lock_cnt_r <= lock_cnt_r - 6'h01;
                    end
                end
                LK_DONE:
                begin
                    pll2_lock_r <= 1'b1;
                end
                default:
                begin
                    pll2_lock_r <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ready flags after a clock switch
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            mrdy_cnt_r <= 2'h0;
            mrdy_r <= 1'b1;
        end
        else if (wr_mclk)
        begin
            mrdy_cnt_r <= 2'(READY_DLY);
            mrdy_r <= 1'b0;
        end
        else if (mrdy_cnt_r != 2'h0)
        begin
            mrdy_cnt_r <= mrdy_cnt_r - 2'h1;
        end
        else
        begin
            mrdy_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            p0_cnt_r <= 2'h0;
            p0rdy_r <= 1'b1;
        end
        else if (wr_pck0)
        begin
            p0_cnt_r <= 2'(READY_DLY);
            p0rdy_r <= 1'b0;
        end
        else if (p0_cnt_r != 2'h0)
        begin
            p0_cnt_r <= p0_cnt_r - 2'h1;
        end
        else
        begin
            p0rdy_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            p1_cnt_r <= 2'h0;
            p1rdy_r <= 1'b1;
        end
        else if (wr_pck1)
        begin
            p1_cnt_r <= 2'(READY_DLY);
            p1rdy_r <= 1'b0;
        end
        else if (p1_cnt_r != 2'h0)
        begin
            p1_cnt_r <= p1_cnt_r - 2'h1;
        end
        else
        begin
            p1rdy_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status word and read port
    always_comb
    begin
        status = 32'h0000_0000;
        status[ST_MOSC] = main_osc_stable_i;
        status[ST_PLL1] = first_pll_locked_i;
        status[ST_PLL2] = pll2_lock_r;
        status[ST_MRDY] = mrdy_r;
        status[ST_OSCSEL] = slow_osc_select_i;
        status[ST_PCK0] = p0rdy_r;
        status[ST_PCK1] = p1rdy_r;
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            rdata_o <= 32'h0000_0000;
        end
        else if (rd_i)
        begin
            case (addr_i)
                PLLB_CFG_OFS: rdata_o <= pllb_r;
                MCLK_CFG_OFS: rdata_o <= mclk_r;
                PCK0_CFG_OFS: rdata_o <= pck0_r;
                PCK1_CFG_OFS: rdata_o <= pck1_r;
                STATUS_OFS: rdata_o <= status;
                IRQ_MASK_OFS: rdata_o <= ien_r;
                default: rdata_o <= 32'h0000_0000;
            endcase
        end
        else
        begin
            rdata_o <= 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(status & ien_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock control outputs
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            second_pll_on_o <= 1'b0;
            second_pll_input_divider_o <= 8'h00;
            second_pll_multiplier_o <= 11'h000;
            second_pll_freq_range_o <= 2'h0;
            usb_div_ratio_o <= 3'h0;
            mclk_source_o <= SRC_SLOW;
            mclk_div_ratio_o <= 7'h01;
            mclk_master_div_o <= 3'h1;
            pck0_source_o <= SRC_SLOW;
            pck0_div_ratio_o <= 7'h01;
            pck1_source_o <= SRC_SLOW;
            pck1_div_ratio_o <= 7'h01;
        end
        else
        begin
            // off when multiplier or divider is zero
            second_pll_on_o <= pllb_r[MULT_LSB +: 11] != 11'h000
                && pllb_r[PDIV_LSB +: 8] != 8'h00;
            second_pll_input_divider_o <= pllb_r[PDIV_LSB +: 8];
            second_pll_multiplier_o <= pllb_r[MULT_LSB +: 11];
            second_pll_freq_range_o <= pllb_r[RANGE_LSB +: 2];
            usb_div_ratio_o <= div2_ratio(pllb_r[USBD_LSB +: 2]);
            mclk_source_o <= mclk_r[SRC_LSB +: 2];
            mclk_div_ratio_o <= prescale_ratio(mclk_r[PSC_LSB +: 3]);
            mclk_master_div_o <= div2_ratio(mclk_r[MCK_DIV_LSB +: 2]);
            pck0_source_o <= pck0_r[SRC_LSB +: 2];
            pck0_div_ratio_o <= prescale_ratio(pck0_r[PSC_LSB +: 3]);
            pck1_source_o <= pck1_r[SRC_LSB +: 2];
            pck1_div_ratio_o <= prescale_ratio(pck1_r[PSC_LSB +: 3]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence pllb_write_s;
        wr_pllb;
    endsequence

    sequence zero_count_write_s;
        wr_pllb && wdata_i[CNTB_LSB +: 6] == 6'h00;
    endsequence

    lock_drop_a: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i) pllb_write_s |=> !pll2_lock_r)
        else $error("lock flag not cleared by config write");
    lock_zero_a: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i)
        zero_count_write_s ##1 !wr_pllb |=> pll2_lock_r)
        else $error("lock flag late for zero count");
    lock_hold_a: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i) $rose(pll2_lock_r) |-> lock_cnt_r == 6'h00)
        else $error("lock flag rose before count ended");
    ien_set_a: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i) (wr_i && addr_i == IRQ_EN_OFS) |=>
        ((ien_r & (wdata_last_r & IRQ_MASK)) == (wdata_last_r & IRQ_MASK)))
        else $error("enable write did not set bits");
    ien_clr_a: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i) (wr_i && addr_i == IRQ_DIS_OFS) |=>
        ((ien_r & wdata_last_r) == 32'h0000_0000))
        else $error("disable write did not clear bits");
    irq_out_a: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i)
        ##1 irq_o == |($past(status) & $past(ien_r)))
        else $error("irq output mismatch");
    mrdy_wait_a: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i) wr_mclk ##1 !wr_mclk [*4] |=> mrdy_r)
        else $error("master ready not restored");
    mrdy_drop_a: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i) wr_mclk |=> !mrdy_r)
        else $error("master ready not dropped by write");
    prescale_map_a: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i)
        ##1 mclk_div_ratio_o == prescale_ratio($past(mclk_r[PSC_LSB +: 3])))
        else $error("prescaler ratio wrong");

    always_ff @(posedge mclk_i)
    begin
        wdata_last_r <= wdata_i;
    end
endmodule

//--- tb/test_pll_b_master_clock_control.sv
`timescale 1ns/10ps
module test_pll_b_master_clock_control;
    import pmcb_pkg::*;
    localparam int LOCK_N = 4;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic slow_tick_i = 1'b0;
    logic main_osc_stable_i = 1'b0;
    logic first_pll_locked_i = 1'b0;
    logic slow_osc_select_i = 1'b0;
    logic [31:0] rdata_o;
    logic irq_o;
    logic second_pll_on_o;
    logic [7:0] pll_div;
    logic [10:0] pll_mul;
    logic [1:0] pll_rng;
    logic [2:0] usb_ratio;
    logic [1:0] mclk_src;
    logic [6:0] mclk_psc;
    logic [2:0] mclk_mdv;
    logic [1:0] pck0_src;
    logic [1:0] pck1_src;
    logic [6:0] pck0_psc;
    logic [6:0] pck1_psc;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 73;
    logic [31:0] en_m = 32'h0000_0000;

    pmcb_top u_dut (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .slow_tick_i(slow_tick_i),
        .main_osc_stable_i(main_osc_stable_i),
        .first_pll_locked_i(first_pll_locked_i),
        .slow_osc_select_i(slow_osc_select_i),
        .rdata_o(rdata_o),
        .irq_o(irq_o),
        .second_pll_on_o(second_pll_on_o),
        .second_pll_input_divider_o(pll_div),
        .second_pll_multiplier_o(pll_mul),
        .second_pll_freq_range_o(pll_rng),
        .usb_div_ratio_o(usb_ratio),
        .mclk_source_o(mclk_src),
        .mclk_div_ratio_o(mclk_psc),
        .mclk_master_div_o(mclk_mdv),
        .pck0_source_o(pck0_src),
        .pck0_div_ratio_o(pck0_psc),
        .pck1_source_o(pck1_src),
        .pck1_div_ratio_o(pck1_psc)
    );

    always #10 mclk_i = ~mclk_i;

    ////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task rd_chk(input string what, input logic [7:0] a,
                input logic [31:0] exp);
        logic [31:0] d;
        bus_rd(a, d);
        chk(what, exp, d);
    endtask

    task tick;
        @(posedge mclk_i);
        slow_tick_i <= 1'b1;
        @(posedge mclk_i);
        slow_tick_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
    endtask

    // bounded poll of one status flag
    task wait_bit(input int b);
        logic [31:0] d;
        int k;
        d = 32'h0000_0000;
        k = 0;
        while (d[b] !== 1'b1 && k < 20)
        begin
            bus_rd(STATUS_OFS, d);
            k++;
        end
        if (d[b] !== 1'b1)
        begin
            n_mismatch++;
            $display("mismatch status bit %0d expected 1 seen %b", b, d[b]);
            final_report;
        end
    endtask

    function automatic logic [31:0] st_exp(input logic lock2);
        st_exp = 32'h0000_0000;
        st_exp[ST_MOSC] = main_osc_stable_i;
        st_exp[ST_PLL1] = first_pll_locked_i;
        st_exp[ST_PLL2] = lock2;
        st_exp[ST_MRDY] = 1'b1;
        st_exp[ST_OSCSEL] = slow_osc_select_i;
        st_exp[ST_PCK0] = 1'b1;
        st_exp[ST_PCK1] = 1'b1;
    endfunction

    function automatic logic [31:0] psc_exp(input logic [2:0] c);
        psc_exp = (c == PSC_RSVD) ? 32'h0000_0000 : (32'h0000_0001 << c);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (100000) @(posedge mclk_i);
        n_mismatch++;
        $display("mismatch watchdog expected done seen hang");
        final_report;
    end

    initial
    begin
        logic [31:0] d;
        int p;
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rd_chk("pll cfg", PLLB_CFG_OFS, PLLB_RST);
        rd_chk("mclk cfg", MCLK_CFG_OFS, MCLK_RST);
        rd_chk("pck0 cfg", PCK0_CFG_OFS, PCK_RST);
        rd_chk("pck1 cfg", PCK1_CFG_OFS, PCK_RST);
        rd_chk("status", STATUS_OFS, st_exp(1'b0));
        rd_chk("unmapped", 8'hF0, 32'h0000_0000);
        chk("irq", 32'h0000_0000, irq_o);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            d = $random(seed);
            d[29:28] = i[1:0];
            if (i < 2)
                d[7:0] = i[7:0];
            if (i == 2)
                d[26:16] = 11'h000;
            bus_wr(PLLB_CFG_OFS, d);
            repeat (2) @(posedge mclk_i);
            #1;
            chk("pll divider", d[7:0], pll_div);
            chk("pll mult", d[26:16], pll_mul);
            chk("pll range", d[15:14], pll_rng);
            chk("pll on", d[7:0] != 0 && d[26:16] != 0,
                second_pll_on_o);
            chk("usb ratio", (i % 4 == 3) ? 0 : (1 << (i % 4)),
                usb_ratio);
            rd_chk("pll cfg", PLLB_CFG_OFS, d & PLLB_MASK);
        end
        $display("test pll fields done");
        bus_wr(IRQ_EN_OFS, 32'h0000_0004);
        en_m = 32'h0000_0004;
        bus_wr(PLLB_CFG_OFS, 32'h0001_0001 | (LOCK_N << CNTB_LSB));
        repeat (2) @(posedge mclk_i);
        repeat (LOCK_N - 1) tick;
        rd_chk("lock early", STATUS_OFS, st_exp(1'b0));
        chk("irq early", 32'h0000_0000, irq_o);
        tick;
        wait_bit(ST_PLL2);
        repeat (2) @(posedge mclk_i);
        #1;
        chk("irq lock", 32'h0000_0001, irq_o);
        $display("test lock counter done");
        for (int i = 0; i < 12; i++)
        begin
            @(posedge mclk_i);
            {main_osc_stable_i, first_pll_locked_i, slow_osc_select_i}
                <= 3'($random(seed));
            d = $random(seed);
            p = (i % 3 == 2) ? IRQ_DIS_OFS : IRQ_EN_OFS;
            bus_wr(p[7:0], d);
            en_m = (p == IRQ_EN_OFS) ? (en_m | d) : (en_m & ~d);
            en_m = en_m & IRQ_MASK;
            rd_chk("enables", IRQ_MASK_OFS, en_m);
            rd_chk("status", STATUS_OFS,
                   st_exp(1'b1));
            chk("irq", |(st_exp(1'b1) & en_m), irq_o);
        end
        $display("test status and irq done");
        for (int i = 0; i < 32; i++)
        begin
            d = $random(seed);
            d[1:0] = i[1:0];
            d[4:2] = i[2:0];
            d[9:8] = i[4:3];
            bus_wr(MCLK_CFG_OFS, d);
            rd_chk("mclk busy", STATUS_OFS,
                   st_exp(1'b1) & ~(32'h0000_0001 << ST_MRDY));
            wait_bit(ST_MRDY);
            chk("mclk source", d[1:0], mclk_src);
            chk("mclk prescale", psc_exp(d[4:2]), mclk_psc);
            p = (d[9:8] == DIV2_RSVD) ? 0 : (1 << d[9:8]);
            chk("mclk divide", p, mclk_mdv);
            rd_chk("mclk cfg", MCLK_CFG_OFS, d & MCLK_MASK);
        end
        $display("test master clock done");
        for (int i = 0; i < 16; i++)
        begin
            p = i / 8;
            d = $random(seed);
            d[1:0] = i[1:0];
            d[4:2] = i[2:0];
            bus_wr(p == 0 ? PCK0_CFG_OFS : PCK1_CFG_OFS, d);
            rd_chk("pck busy", STATUS_OFS,
                   st_exp(1'b1) & ~(32'h0000_0001 << (ST_PCK0 + p)));
            wait_bit(p == 0 ? ST_PCK0 : ST_PCK1);
            chk("pck source", d[1:0], p == 0 ? pck0_src : pck1_src);
            chk("pck prescale", psc_exp(d[4:2]),
                p == 0 ? pck0_psc : pck1_psc);
            rd_chk("pck cfg", p == 0 ? PCK0_CFG_OFS : PCK1_CFG_OFS,
                   d & PCK_MASK);
        end
        $display("test programmable clocks done");
        final_report;
    end
endmodule
